//--- verilog/emrs_read_seq.sv
// read-cycle sequencer and programmable strobe generator
`include "emrs_regs.svh"
`default_nettype none
module emrs_read_seq #(
  parameter int unsigned UNIT_DIV = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [29:0] addr,
  input wire logic cfg_load,
  input wire emrs_pkg::emrs_cfg_type cfg_in,
  input wire logic wait_request,
  input wire logic [31:0] bus_in,
  output logic [31:0] bus_out,
  output logic [31:0] bus_oe,
  output logic read_strobe_n,
  output logic fixed_strobe_n,
  output logic config_duration_strobe_n,
  output logic delayed_strobe_a_n,
  output logic delayed_strobe_b_n,
  output logic delayed_strobe_c_n,
  output logic proc_clock_output,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic busy
);
  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic wait_s1, wait_s2;
  logic [31:0] bus_s1, bus_s2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
      bus_s1 <= 32'h0;
      bus_s2 <= 32'h0;
    end else begin
      wait_s1 <= wait_request;
      wait_s2 <= wait_s1;
      bus_s1 <= bus_in;
      bus_s2 <= bus_s1;
    end
  end
  // ***************************************************************
  // half clock unit divider
  // ***************************************************************
  logic [7:0] div_cnt, next_div_cnt;
  logic unit_tick;
  logic pclk, next_pclk;
  assign unit_tick = (div_cnt == 8'(UNIT_DIV - 1));
  always_comb begin
    next_div_cnt = unit_tick ? 8'h00 : div_cnt + 8'h01;
    next_pclk = pclk;
    if (unit_tick) begin
      next_pclk = ~pclk;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 8'h00;
      pclk <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      pclk <= next_pclk;
    end
  end
  // ***************************************************************
  // configuration storage
  // ***************************************************************
  emrs_pkg::emrs_cfg_type cfg, next_cfg;
  logic cfg_done, next_cfg_done;
  always_comb begin
    next_cfg = cfg;
    next_cfg_done = cfg_done;
    // one shot only; later loads ignored so all cycles match
    if (cfg_load && !cfg_done) begin
      next_cfg = cfg_in;
      next_cfg_done = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= '{p1: `EMRS_PHASE_DEFAULT, p2: `EMRS_PHASE_DEFAULT,
               p3: `EMRS_PHASE_DEFAULT, p4: `EMRS_PHASE_DEFAULT,
               p5: `EMRS_PHASE_DEFAULT, p6: `EMRS_PHASE6_DEFAULT,
               s1_len: `EMRS_S1_DEFAULT, dly_a: `EMRS_DLY_DEFAULT,
               dly_b: `EMRS_DLY_DEFAULT, dly_c: `EMRS_DLY_DEFAULT};
      cfg_done <= 1'b0;
    end else begin
      cfg <= next_cfg;
      cfg_done <= next_cfg_done;
    end
  end
  // ***************************************************************
  // phase sequencer
  // ***************************************************************
  emrs_pkg::emrs_state_type state, next_state;
  logic [2:0] ph_cnt, next_ph_cnt;
  logic [5:0] s2_cnt, next_s2_cnt;
  logic [2:0] ph_len;
  logic ph_last;
  logic [29:0] addr_q, next_addr_q;
  always_comb begin
    case (state)
      emrs_pkg::ST_P1: ph_len = cfg.p1;
      emrs_pkg::ST_P2: ph_len = cfg.p2;
      emrs_pkg::ST_P3: ph_len = cfg.p3;
      emrs_pkg::ST_P4: ph_len = cfg.p4;
      emrs_pkg::ST_P5: ph_len = cfg.p5;
      emrs_pkg::ST_P6: ph_len = cfg.p6;
      default: ph_len = 3'h1;
    endcase
  end
  // zero length treated as one unit
  assign ph_last = (ph_cnt + 3'h1 >= ph_len);
  always_comb begin
    next_state = state;
    next_ph_cnt = ph_cnt;
    next_s2_cnt = s2_cnt;
    next_addr_q = addr_q;
    case (state)
      emrs_pkg::ST_IDLE: begin
        if (start && unit_tick && !pclk) begin
          next_state = emrs_pkg::ST_P1;
          next_ph_cnt = 3'h0;
          next_addr_q = addr;
        end
      end
      default: begin
        if (unit_tick) begin
          if (state != emrs_pkg::ST_P1 && s2_cnt != 6'h3f) begin
            next_s2_cnt = s2_cnt + 6'h01;
          end
          if (!ph_last) begin
            next_ph_cnt = ph_cnt + 3'h1;
          end else if (state == emrs_pkg::ST_P4 && wait_s2) begin
            next_ph_cnt = ph_cnt;
          end else begin
            next_ph_cnt = 3'h0;
            case (state)
              emrs_pkg::ST_P1: begin
                next_state = emrs_pkg::ST_P2;
                next_s2_cnt = 6'h00;
              end
              emrs_pkg::ST_P2: next_state = emrs_pkg::ST_P3;
              emrs_pkg::ST_P3: next_state = emrs_pkg::ST_P4;
              emrs_pkg::ST_P4: next_state = emrs_pkg::ST_P5;
              emrs_pkg::ST_P5: next_state = emrs_pkg::ST_P6;
              default: next_state = emrs_pkg::ST_IDLE;
            endcase
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= emrs_pkg::ST_IDLE;
      ph_cnt <= 3'h0;
      s2_cnt <= 6'h00;
      addr_q <= 30'h0;
    end else begin
      state <= next_state;
      ph_cnt <= next_ph_cnt;
      s2_cnt <= next_s2_cnt;
      addr_q <= next_addr_q;
    end
  end
  // ***************************************************************
  // strobes, bus and capture
  // ***************************************************************
  logic in_p25;
  logic end_p5;
  logic [31:0] next_bus_out, next_bus_oe, next_rd_data;
  logic next_rd_valid;
  emrs_pkg::emrs_strobe_type stb_n, next_stb_n;
  logic next_rd_n;
  assign in_p25 = (state == emrs_pkg::ST_P2) || (state == emrs_pkg::ST_P3) ||
                  (state == emrs_pkg::ST_P4) || (state == emrs_pkg::ST_P5);
  assign end_p5 = (state == emrs_pkg::ST_P5) && unit_tick && ph_last;
  function automatic logic dly_low(input logic [4:0] dly, input logic [5:0] cnt);
    dly_low = (dly != 5'h00) && (cnt >= {1'b0, dly});
  endfunction : dly_low
  always_comb begin
    next_stb_n = '1;
    next_rd_n = 1'b1;
    next_bus_out = 32'h0;
    next_bus_oe = 32'h0;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    case (next_state)
      emrs_pkg::ST_P1, emrs_pkg::ST_P2: begin
        // full word address, no byte lanes for reads
        next_bus_out = {next_addr_q, 1'b1, 1'b1};
        next_bus_oe = 32'hffffffff;
      end
      default: begin
        next_bus_oe = 32'h0;
      end
    endcase
    if (next_state == emrs_pkg::ST_P4 || next_state == emrs_pkg::ST_P5) begin
      next_rd_n = 1'b0;
    end
    if (next_state == emrs_pkg::ST_P2 || next_state == emrs_pkg::ST_P3 ||
        next_state == emrs_pkg::ST_P4 || next_state == emrs_pkg::ST_P5) begin
      next_stb_n.fixed = 1'b0;
      next_stb_n.dly_a = ~dly_low(cfg.dly_a, next_s2_cnt);
      next_stb_n.dly_b = ~dly_low(cfg.dly_b, next_s2_cnt);
      next_stb_n.dly_c = ~dly_low(cfg.dly_c, next_s2_cnt);
    end
    if (next_state != emrs_pkg::ST_IDLE && next_state != emrs_pkg::ST_P1) begin
      // ends after s1_len units from p2 start, or at p6 close if sooner since idle forces high
      next_stb_n.dur = ~(next_s2_cnt < {1'b0, cfg.s1_len});
    end
    if (end_p5) begin
      next_rd_data = bus_s2;
      next_rd_valid = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_n <= '1;
      read_strobe_n <= 1'b1;
      bus_out <= 32'h0;
      bus_oe <= 32'h0;
      rd_data <= 32'h0;
      rd_valid <= 1'b0;
      busy <= 1'b0;
      proc_clock_output <= 1'b0;
    end else begin
      stb_n <= next_stb_n;
      read_strobe_n <= next_rd_n;
      bus_out <= next_bus_out;
      bus_oe <= next_bus_oe;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      busy <= (next_state != emrs_pkg::ST_IDLE);
      proc_clock_output <= next_pclk;
    end
  end
  assign fixed_strobe_n = stb_n.fixed;
  assign config_duration_strobe_n = stb_n.dur;
  assign delayed_strobe_a_n = stb_n.dly_a;
  assign delayed_strobe_b_n = stb_n.dly_b;
  assign delayed_strobe_c_n = stb_n.dly_c;
  // ***************************************************************
  // checks
  // ***************************************************************
  property p_rd_phase;
    @(posedge clk) disable iff (!rst_b)
      read_strobe_n == !(state == emrs_pkg::ST_P4 || state == emrs_pkg::ST_P5);
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read strobe high in p4/p5");
  property p_fixed;
    @(posedge clk) disable iff (!rst_b)
      $rose(state == emrs_pkg::ST_P2) |-> !fixed_strobe_n;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed strobe not low in p2");
  property p_capture;
    @(posedge clk) disable iff (!rst_b) end_p5 |=> rd_valid && rd_data == $past(bus_s2);
  endproperty
  a_capture: assert property (p_capture) else $error("read data not captured");
  property p_dur_zero;
    @(posedge clk) disable iff (!rst_b) (cfg.s1_len == 5'h00) |=> config_duration_strobe_n;
  endproperty
  a_dur_zero: assert property (p_dur_zero) else $error("zero duration strobe low");
  property p_dly_zero;
    @(posedge clk) disable iff (!rst_b) (cfg.dly_a == 5'h00) |=> delayed_strobe_a_n;
  endproperty
  a_dly_zero: assert property (p_dly_zero) else $error("zero delay strobe low");
  property p_idle_high;
    @(posedge clk) disable iff (!rst_b)
      (state == emrs_pkg::ST_IDLE) |-> ##1 (config_duration_strobe_n && delayed_strobe_b_n);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("strobe low outside cycle");
  property p_wait_hold;
    @(posedge clk) disable iff (!rst_b)
      (state == emrs_pkg::ST_P4 && ph_last && wait_s2) |=> state == emrs_pkg::ST_P4;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait did not stretch p4");
  property p_bus_off;
    @(posedge clk) disable iff (!rst_b)
      (state == emrs_pkg::ST_P3 || state == emrs_pkg::ST_P5) |=> bus_oe == 32'h0;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus driven in data phase");
endmodule : emrs_read_seq
`default_nettype wire

//--- verilog/emrs_regs.svh
// constants for the external memory read strobe sequencer
`ifndef EMRS_REGS_SVH
`define EMRS_REGS_SVH
`define EMRS_PHASE_DEFAULT 3'h4
`define EMRS_PHASE6_DEFAULT 3'h4
`define EMRS_S1_DEFAULT 5'h00
`define EMRS_DLY_DEFAULT 5'h00
`define EMRS_CLK_HZ 125000000
`define EMRS_BUS_W 32
`endif

//--- verilog/emrs_pkg.sv
// types for the external memory read strobe sequencer
`default_nettype none
package emrs_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_P1 = 7'h02,
    ST_P2 = 7'h04,
    ST_P3 = 7'h08,
    ST_P4 = 7'h10,
    ST_P5 = 7'h20,
    ST_P6 = 7'h40
  } emrs_state_type;
  typedef struct packed {
    logic [2:0] p1;
    logic [2:0] p2;
    logic [2:0] p3;
    logic [2:0] p4;
    logic [2:0] p5;
    logic [2:0] p6;
    logic [4:0] s1_len;
    logic [4:0] dly_a;
    logic [4:0] dly_b;
    logic [4:0] dly_c;
  } emrs_cfg_type;
  typedef struct packed {
    logic fixed;
    logic dur;
    logic dly_a;
    logic dly_b;
    logic dly_c;
  } emrs_strobe_type;
endpackage : emrs_pkg
`default_nettype wire

//--- verif/emrs_mem_model.sv
// memory partner model answering read cycles
`default_nettype none
// ****
// model
// ****
module emrs_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic read_strobe_n,
  input wire logic [31:0] bus_out,
  input wire logic [31:0] bus_oe,
  output logic [31:0] bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [29:0] word_addr;
  logic [31:0] drive;
  logic hold;
  // released bus alternates the last read word with its complement, so a stale word shows every other cycle
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & drive);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_addr <= 30'h0;
      drive <= 32'h0;
      hold <= 1'b0;
    end else begin
      hold <= !read_strobe_n;
      if (&bus_oe) word_addr <= bus_out[31:2];
      if (!read_strobe_n) drive <= {word_addr, 2'h0} ^ 32'h5a3c_96e1;
      else if (!hold) drive <= ~drive;
    end
  end
endmodule : emrs_mem_model
`default_nettype wire

//--- verif/emrs_tb.sv
// self-checking bench for the read strobe sequencer
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
// ****
// bench
// ****
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [29:0] addr; logic waited;} emrs_exp_type;
  logic clk = 0, rst_b = 0, start = 0, cfg_load = 0, wait_request = 0;
  logic wait_mode = 0, wait_used = 0, pc_last = 0, pc_seen = 0, busy_last = 0;
  logic [29:0] addr = '0;
  emrs_pkg::emrs_cfg_type cfg_in = '0, cfg;
  logic [31:0] bus_in, bus_out, bus_oe, rd_data, seed = 32'h0000_5500;
  logic read_strobe_n, fixed_strobe_n, config_duration_strobe_n, proc_clock_output;
  logic delayed_strobe_a_n, delayed_strobe_b_n, delayed_strobe_c_n, rd_valid, busy;
  int miscompares = 0, compares = 0, cycles = 0, wait_left = 0, gap = 0, valids = 0;
  int lows[7] = '{default: 0};
  emrs_exp_type exp_q[$];
  always #4 clk = ~clk;
  emrs_read_seq #(.UNIT_DIV(2)) u_dut (.clk, .rst_b, .start, .addr, .cfg_load, .cfg_in,
    .wait_request, .bus_in, .bus_out, .bus_oe, .read_strobe_n, .fixed_strobe_n,
    .config_duration_strobe_n, .delayed_strobe_a_n, .delayed_strobe_b_n,
    .delayed_strobe_c_n, .proc_clock_output, .rd_data, .rd_valid, .busy);
  emrs_mem_model u_mem (.clk, .rst_b, .read_strobe_n, .bus_out, .bus_oe, .bus_in);
  function logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt
  function automatic int ph(input logic [2:0] x);
    return (x == 3'h0) ? 1 : int'(x);
  endfunction : ph
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 3000 && busy !== v; n++) @(negedge clk);
    `CHK("busy", v, busy);
  endtask : wait_busy
  task automatic do_read(input logic w);
    logic [31:0] r;
    r = nxt();
    exp_q.push_back('{r[29:0], w});
    wait_mode = w;
    wait_used = 1'b0;
    addr = r[29:0];
    start = 1'b1;
    wait_busy(1'b1);
    start = 1'b0;
    wait_busy(1'b0);
    @(negedge clk);
  endtask : do_read
  task automatic load(input emrs_pkg::emrs_cfg_type c);
    cfg_in = c;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
    @(negedge clk);
  endtask : load
  // wait raised early in phase 2 so the synchroniser sees it before phase 4 ends
  always @(negedge clk) begin
    if (wait_left > 0) begin
      wait_left--;
      wait_request = (wait_left > 0);
    end else if (wait_mode && !wait_used && fixed_strobe_n === 1'b0) begin
      wait_used = 1'b1;
      wait_left = 20 + int'(nxt() % 8);
      wait_request = 1'b1;
    end
  end
  always @(negedge clk) begin : mon
    logic [6:0] lo;
    emrs_exp_type e;
    int sp, w, d;
    lo = {~read_strobe_n, ~fixed_strobe_n, ~config_duration_strobe_n, ~delayed_strobe_a_n,
      ~delayed_strobe_b_n, ~delayed_strobe_c_n, &bus_oe};
    for (int i = 0; i < 7; i++) lows[i] += int'(lo[i]);
    if (&bus_oe) `CHK("addr", {exp_q[0].addr, 2'h3}, bus_out);
    if (rd_valid === 1'b1) begin
      valids++;
      `CHK("data", {exp_q[0].addr, 2'h0} ^ 32'h5a3c_96e1, rd_data);
    end
    gap++;
    if (proc_clock_output !== pc_last) begin
      if (pc_seen) `CHK("unit", 2, gap);
      pc_seen = rst_b;
      gap = 0;
      pc_last = proc_clock_output;
    end
    if (busy_last === 1'b1 && busy === 1'b0) begin
      e = exp_q.pop_front();
      sp = ph(cfg.p2) + ph(cfg.p3) + ph(cfg.p4) + ph(cfg.p5);
      w = lows[5] / 2 - sp;
      if (e.waited) `CHK("waits", 1, w > 0);
      else `CHK("fixed", 2 * sp, lows[5]);
      `CHK("read", 2 * (ph(cfg.p4) + ph(cfg.p5) + w), lows[6]);
      `CHK("oe", 2 * (ph(cfg.p1) + ph(cfg.p2)), lows[0]);
      `CHK("valid", 1, valids);
      d = (sp + w + ph(cfg.p6) < cfg.s1_len) ? sp + w + ph(cfg.p6) : int'(cfg.s1_len);
      `CHK("dur", 2 * d, lows[4]);
      for (int i = 1; i < 4; i++) begin
        d = (i == 3) ? cfg.dly_a : (i == 2) ? cfg.dly_b : cfg.dly_c;
        `CHK("delayed", (d == 0 || d >= sp + w) ? 0 : 2 * (sp + w - d), lows[i]);
      end
      lows = '{default: 0};
      valids = 0;
    end
    busy_last = busy;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    cfg = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 5'h00, 5'h00, 5'h00, 5'h00};
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    do_read(1'b0);
    // duration forced at phase 6 end without waits, runs its full s1_len of 12 units with waits
    cfg = '{3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h5, 5'h0c, 5'h01, 5'h05, 5'h00};
    load(cfg);
    load('{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 5'h02, 5'h02, 5'h02, 5'h02});
    do_read(1'b0);
    do_read(1'b1);
    repeat (12) do_read(^nxt());
    test_done();
  end
endmodule : testbench
`default_nettype wire
